/* rtl/mqu_pkg.sv */
// Package with register offsets, field positions and reset values of the message queue unit.
package mqu_pkg;
  localparam int MQU_DATA_W = 32;
  localparam int MQU_ADDR_W = 12;
  localparam int MQU_DEPTH = 32;
  localparam logic [11:0] MQU_OFF_HOST_STATUS = 12'h030;
  localparam logic [11:0] MQU_OFF_HOST_MASK = 12'h034;
  localparam logic [11:0] MQU_OFF_LOCAL_STATUS = 12'h038;
  localparam logic [11:0] MQU_OFF_LOCAL_MASK = 12'h03C;
  localparam logic [11:0] MQU_OFF_IBFP_PORT = 12'h040;
  localparam logic [11:0] MQU_OFF_OBPF_PORT = 12'h044;
  localparam logic [11:0] MQU_OFF_IBPF_PORT = 12'h048;
  localparam logic [11:0] MQU_OFF_OBFP_PORT = 12'h04C;
  localparam int MQU_FLAG_BIT = 3;
  localparam logic MQU_MASK_RESET = 1'b1;
  localparam logic [31:0] MQU_EMPTY_WORD = 32'hFFFFFFFF;
  localparam logic [31:0] MQU_MASK_FILL = 32'hFFFFFFF7;
  localparam logic [1:0] MQU_Q_IN_FREE = 2'h0;
  localparam logic [1:0] MQU_Q_IN_POST = 2'h1;
  localparam logic [1:0] MQU_Q_OUT_POST = 2'h2;
  localparam logic [1:0] MQU_Q_OUT_FREE = 2'h3;
endpackage

/* rtl/mqu_mem.sv */
// Register-output word memory that stores one queue's entries.
`timescale 1ns/1ps
`default_nettype none
module mqu_mem #(
  parameter int DATA_W = 32,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem_q [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    rd_data <= mem_q[rd_addr];
  end
endmodule
`default_nettype wire

/* rtl/mqu_queue.sv */
// One message queue with pointers, occupancy count and a registered head word.
`timescale 1ns/1ps
`default_nettype none
module mqu_queue #(
  parameter int DATA_W = 32,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic push,
  input wire logic [DATA_W-1:0] push_data,
  input wire logic pop,
  output logic [DATA_W-1:0] head,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic do_push;
  logic do_pop;
  logic [AW-1:0] rd_addr;

  assign empty = (count_q == '0);
  assign full = (count_q == (AW+1)'(DEPTH));
  // Full queues drop writes and empty queues ignore pops.
  assign do_push = push && !full; // RULE12
  assign do_pop = pop && !empty; // RULE11
  // The memory is read ahead so that the head word is ready after each pop.
  assign rd_addr = do_pop ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_q <= '0; // RULE13
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= AW'(wr_ptr_q + 1'b1); // RULE14
      end
      if (do_pop) begin
        rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
      end
      if (do_push && !do_pop) begin
        count_q <= (AW+1)'(count_q + 1'b1);
      end else if (do_pop && !do_push) begin
        count_q <= (AW+1)'(count_q - 1'b1);
      end
    end
  end

  // A word written to an empty slot at the read pointer becomes visible one cycle
  // later; a bypass register covers that case.
  logic [DATA_W-1:0] mem_rd;
  logic [DATA_W-1:0] byp_q;
  logic byp_sel_q;
  always_ff @(posedge ref_clk) begin
    byp_q <= push_data;
    byp_sel_q <= do_push && (wr_ptr_q == rd_addr);
  end
  assign head = byp_sel_q ? byp_q : mem_rd;

  mqu_mem #(.DATA_W(DATA_W), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .ref_clk(ref_clk),
    .wr_en(do_push),
    .wr_addr(wr_ptr_q),
    .wr_data(push_data),
    .rd_addr(rd_addr),
    .rd_data(mem_rd)
  );

  AST_FULL_DROP: assert property (@(posedge ref_clk) disable iff (rst)
    full && push && !pop |=> full && $stable(wr_ptr_q)) // RULE12
    else $error("Write to a full queue changed it.");
endmodule
`default_nettype wire

/* rtl/mqu_top.sv */
// Top of the message queue unit: register decode, four queues and interrupt requests.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: Host status bit 3 is 1 while outbound post queue is not empty.
// RULE2: Local status bit 3 is 1 while inbound post queue holds data.
// RULE3: Each mask bit 3 masks its side's interrupt; resets to 1.
// RULE4: Other mask register bits read as 1.
// RULE5: Other unused bits in this group read as 0.
// RULE6: Registers decode as word-aligned byte offsets in the window.
// RULE7: Offset 0x40 reads inbound free, writes inbound post.
// RULE8: Offset 0x44 reads outbound post, writes outbound free.
// RULE9: Offset 0x48 reads inbound post, writes inbound free.
// RULE10: Offset 0x4C reads outbound free, writes outbound post.
// RULE11: Reading an empty queue returns all ones and changes nothing.
// RULE12: Writing a full queue is discarded, contents unchanged.
// RULE13: Queues start empty and reset empties all of them.
// RULE14: Each queue holds 32 words, tracked by pointers and a count.
// RULE15: Side interrupt asserts while status is 1 and mask is 0.
module mqu_top
  import mqu_pkg::*;
#(
  parameter int DEPTH = mqu_pkg::MQU_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [mqu_pkg::MQU_ADDR_W-1:0] host_addr,
  input wire logic [mqu_pkg::MQU_DATA_W-1:0] host_wdata,
  output logic [mqu_pkg::MQU_DATA_W-1:0] host_rdata,
  input wire logic local_rd,
  input wire logic local_wr,
  input wire logic [mqu_pkg::MQU_ADDR_W-1:0] local_addr,
  input wire logic [mqu_pkg::MQU_DATA_W-1:0] local_wdata,
  output logic [mqu_pkg::MQU_DATA_W-1:0] local_rdata,
  output logic host_irq,
  output logic local_irq
);
  import mqu_pkg::*;

  logic host_mask_q;
  logic local_mask_q;
  logic [3:0] q_push;
  logic [3:0] q_pop;
  logic [3:0] q_empty;
  logic [3:0] q_full;
  logic [MQU_DATA_W-1:0] q_head [4];
  logic [MQU_DATA_W-1:0] q_wdata [4];
  logic host_status;
  logic local_status;

  // Host and local buses share one map; the host has priority on a queue
  // when both touch it in the same cycle, and the local access is dropped.
  function automatic logic [1:0] rd_sel(input logic [11:0] a);
    if (a == MQU_OFF_IBFP_PORT) begin
      rd_sel = MQU_Q_IN_FREE; // RULE7
    end else if (a == MQU_OFF_OBPF_PORT) begin
      rd_sel = MQU_Q_OUT_POST; // RULE8
    end else if (a == MQU_OFF_IBPF_PORT) begin
      rd_sel = MQU_Q_IN_POST; // RULE9
    end else begin
      rd_sel = MQU_Q_OUT_FREE; // RULE10
    end
  endfunction

  function automatic logic [1:0] wr_sel(input logic [11:0] a);
    if (a == MQU_OFF_IBFP_PORT) begin
      wr_sel = MQU_Q_IN_POST; // RULE7
    end else if (a == MQU_OFF_OBPF_PORT) begin
      wr_sel = MQU_Q_OUT_FREE; // RULE8
    end else if (a == MQU_OFF_IBPF_PORT) begin
      wr_sel = MQU_Q_IN_FREE; // RULE9
    end else begin
      wr_sel = MQU_Q_OUT_POST; // RULE10
    end
  endfunction

  function automatic logic is_port(input logic [11:0] a);
    is_port = (a == MQU_OFF_IBFP_PORT) || (a == MQU_OFF_OBPF_PORT) ||
              (a == MQU_OFF_IBPF_PORT) || (a == MQU_OFF_OBFP_PORT); // RULE6
  endfunction

  logic h_port;
  logic l_port;
  assign h_port = is_port(host_addr);
  assign l_port = is_port(local_addr);

  always_comb begin
    q_push = '0;
    q_pop = '0;
    for (int i = 0; i < 4; i++) begin
      q_wdata[i] = local_wdata;
    end
    if (local_wr && l_port) begin
      q_push[wr_sel(local_addr)] = 1'b1;
    end
    if (local_rd && l_port) begin
      q_pop[rd_sel(local_addr)] = 1'b1;
    end
    if (host_wr && h_port) begin
      q_push[wr_sel(host_addr)] = 1'b1;
      q_wdata[wr_sel(host_addr)] = host_wdata;
    end
    if (host_rd && h_port) begin
      q_pop[rd_sel(host_addr)] = 1'b1;
    end
    if (local_wr && l_port && host_rd && h_port && rd_sel(host_addr) == wr_sel(local_addr)) begin
      q_push[wr_sel(local_addr)] = 1'b0;
    end
    if (local_rd && l_port && host_wr && h_port && rd_sel(local_addr) == wr_sel(host_addr)) begin
      q_pop[rd_sel(local_addr)] = 1'b0;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_queue
    mqu_queue #(.DATA_W(MQU_DATA_W), .DEPTH(DEPTH)) u_queue (
      .ref_clk(ref_clk),
      .rst(rst), // RULE13
      .push(q_push[g]),
      .push_data(q_wdata[g]),
      .pop(q_pop[g]),
      .head(q_head[g]),
      .empty(q_empty[g]),
      .full(q_full[g])
    );
  end

  assign host_status = !q_empty[MQU_Q_OUT_POST]; // RULE1
  assign local_status = !q_empty[MQU_Q_IN_POST]; // RULE2

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      host_mask_q <= MQU_MASK_RESET; // RULE3
    end else if (host_wr && host_addr == MQU_OFF_HOST_MASK) begin
      host_mask_q <= host_wdata[MQU_FLAG_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      local_mask_q <= MQU_MASK_RESET; // RULE3
    end else if (local_wr && local_addr == MQU_OFF_LOCAL_MASK) begin
      local_mask_q <= local_wdata[MQU_FLAG_BIT];
    end
  end

  assign host_irq = host_status && !host_mask_q; // RULE15
  assign local_irq = local_status && !local_mask_q; // RULE15

  // Read data for one register bus; queue reads return the head captured this cycle.
  function automatic logic [31:0] rd_word(input logic [11:0] a, input logic [3:0] emp,
                                          input logic [31:0] h0, input logic [31:0] h1,
                                          input logic [31:0] h2, input logic [31:0] h3,
                                          input logic hs, input logic ls,
                                          input logic hm, input logic lm);
    logic [1:0] s;
    logic [31:0] hd;
    s = rd_sel(a);
    hd = (s == 2'h0) ? h0 : (s == 2'h1) ? h1 : (s == 2'h2) ? h2 : h3;
    rd_word = 32'h00000000; // RULE5
    if (a == MQU_OFF_HOST_STATUS) begin
      rd_word[MQU_FLAG_BIT] = hs; // RULE1
    end else if (a == MQU_OFF_HOST_MASK) begin
      rd_word = MQU_MASK_FILL; // RULE4
      rd_word[MQU_FLAG_BIT] = hm;
    end else if (a == MQU_OFF_LOCAL_STATUS) begin
      rd_word[MQU_FLAG_BIT] = ls; // RULE2
    end else if (a == MQU_OFF_LOCAL_MASK) begin
      rd_word = MQU_MASK_FILL; // RULE4
      rd_word[MQU_FLAG_BIT] = lm;
    end else if (is_port(a)) begin
      rd_word = emp[s] ? MQU_EMPTY_WORD : hd; // RULE11
    end
  endfunction

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      host_rdata <= '0;
    end else if (host_rd) begin
      host_rdata <= rd_word(host_addr, q_empty, q_head[0], q_head[1], q_head[2], q_head[3],
                            host_status, local_status, host_mask_q, local_mask_q);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      local_rdata <= '0;
    end else if (local_rd) begin
      if (host_rd && h_port && l_port && rd_sel(host_addr) == rd_sel(local_addr)) begin
        local_rdata <= MQU_EMPTY_WORD;
      end else if (host_wr && h_port && l_port && wr_sel(host_addr) == rd_sel(local_addr)) begin
        local_rdata <= MQU_EMPTY_WORD;
      end else begin
        local_rdata <= rd_word(local_addr, q_empty, q_head[0], q_head[1], q_head[2], q_head[3],
                               host_status, local_status, host_mask_q, local_mask_q);
      end
    end
  end

  AST_HOST_IRQ: assert property (@(posedge ref_clk) disable iff (rst)
    host_irq == (!q_empty[2] && !host_mask_q)) // RULE15
    else $error("Host interrupt does not follow status and mask.");
  AST_EMPTY_READ: assert property (@(posedge ref_clk) disable iff (rst)
    host_rd && host_addr == MQU_OFF_OBPF_PORT && q_empty[2] |=> host_rdata == 32'hFFFFFFFF) // RULE11
    else $error("Empty queue read did not return all ones.");
  AST_MASK_READ: assert property (@(posedge ref_clk) disable iff (rst)
    host_rd && host_addr == MQU_OFF_HOST_MASK |=> host_rdata[31:4] == 28'hFFFFFFF) // RULE4
    else $error("Mask register unused bits not ones.");
  AST_MASK_RESET: assert property (@(posedge ref_clk) $past(rst) |-> host_mask_q && local_mask_q) // RULE3
    else $error("Mask bits not set after reset.");
  AST_RESET_EMPTY: assert property (@(posedge ref_clk) $past(rst) |-> q_empty == 4'hF) // RULE13
    else $error("Queues not empty after reset.");
  AST_POST_STATUS: assert property (@(posedge ref_clk) disable iff (rst)
    local_wr && local_addr == MQU_OFF_OBFP_PORT && !q_full[2] && !(host_rd && h_port)
    |=> host_status) // RULE1
    else $error("Outbound post status did not rise after a post.");
  AST_IN_STATUS: assert property (@(posedge ref_clk) disable iff (rst)
    host_wr && host_addr == MQU_OFF_IBFP_PORT && !q_full[1] |=> local_status) // RULE2
    else $error("Inbound post status did not rise after a post.");
  AST_STATUS_READ: assert property (@(posedge ref_clk) disable iff (rst)
    local_rd && local_addr == MQU_OFF_LOCAL_STATUS |=> local_rdata == {28'h0000000, $past(local_status), 3'h0}) // RULE5
    else $error("Local status read wrong.");

  // Host read strobe at one given offset.
  sequence s_host_rd_at(logic [11:0] off);
    host_rd && host_addr == off;
  endsequence

  // Local read strobe at one given offset, with no host queue access beside it.
  sequence s_local_rd_at(logic [11:0] off);
    local_rd && local_addr == off && !(host_rd && h_port) && !(host_wr && h_port);
  endsequence

  // Host write strobe at its own mask register.
  sequence s_host_mask_wr;
    host_wr && host_addr == MQU_OFF_HOST_MASK;
  endsequence

  // Local write strobe at its own mask register.
  sequence s_local_mask_wr;
    local_wr && local_addr == MQU_OFF_LOCAL_MASK;
  endsequence

  AST_LOCAL_IRQ: assert property (@(posedge ref_clk) disable iff (rst) // RULE15
    local_irq == (!q_empty[1] && !local_mask_q))
    else $error("Local interrupt does not follow status and mask.");

  AST_HOST_OUT_POST_POP: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
    s_host_rd_at(MQU_OFF_OBPF_PORT) ##0 !q_empty[2] |=> host_rdata == $past(q_head[2]))
    else $error("Host read of outbound post returned the wrong word.");

  AST_HOST_IN_FREE_POP: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
    s_host_rd_at(MQU_OFF_IBFP_PORT) ##0 !q_empty[0] |=> host_rdata == $past(q_head[0]))
    else $error("Host read of inbound free returned the wrong word.");

  AST_LOCAL_IN_POST_POP: assert property (@(posedge ref_clk) disable iff (rst) // RULE9
    s_local_rd_at(MQU_OFF_IBPF_PORT) ##0 !q_empty[1] |=> local_rdata == $past(q_head[1]))
    else $error("Local read of inbound post returned the wrong word.");

  AST_LOCAL_OUT_FREE_POP: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
    s_local_rd_at(MQU_OFF_OBFP_PORT) ##0 !q_empty[3] |=> local_rdata == $past(q_head[3]))
    else $error("Local read of outbound free returned the wrong word.");

  AST_LOCAL_EMPTY_READ: assert property (@(posedge ref_clk) disable iff (rst) // RULE11
    s_local_rd_at(MQU_OFF_IBPF_PORT) ##0 q_empty[1] |=> local_rdata == MQU_EMPTY_WORD)
    else $error("Local read of an empty queue did not return all ones.");

  AST_HOST_MASK_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    s_host_mask_wr |=> host_mask_q == $past(host_wdata[MQU_FLAG_BIT]))
    else $error("Host mask bit did not take the written value.");

  AST_LOCAL_MASK_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    s_local_mask_wr |=> local_mask_q == $past(local_wdata[MQU_FLAG_BIT]))
    else $error("Local mask bit did not take the written value.");

  AST_HOST_MASK_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    !(host_wr && host_addr == MQU_OFF_HOST_MASK) |=> $stable(host_mask_q))
    else $error("Host mask bit changed without a write.");

  AST_LOCAL_MASK_READ: assert property (@(posedge ref_clk) disable iff (rst) // RULE4
    local_rd && local_addr == MQU_OFF_LOCAL_MASK
    |=> local_rdata[31:4] == 28'hFFFFFFF && local_rdata[2:0] == 3'h7)
    else $error("Local mask register unused bits not ones.");

  AST_UNMAPPED_READ: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
    host_rd && !h_port && host_addr != MQU_OFF_HOST_STATUS && host_addr != MQU_OFF_HOST_MASK &&
    host_addr != MQU_OFF_LOCAL_STATUS && host_addr != MQU_OFF_LOCAL_MASK |=> host_rdata == '0)
    else $error("Unmapped read did not return zero.");

  AST_HOST_STATUS_READ: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
    s_host_rd_at(MQU_OFF_HOST_STATUS) |=> host_rdata == {28'h0000000, $past(host_status), 3'h0})
    else $error("Host status read wrong.");

  AST_RESET_OUTPUTS: assert property (@(posedge ref_clk) // RULE13
    $past(rst) |-> host_rdata == '0 && local_rdata == '0 && !host_irq && !local_irq)
    else $error("Outputs not quiet after reset.");
endmodule
`default_nettype wire

/* dv/mqu_bus_agent.sv */
// Bus master model for one side of the message queue unit.
`timescale 1ns/1ps
`default_nettype none
module mqu_bus_agent (
  input wire logic ref_clk,
  output logic rd,
  output logic wr,
  output logic [11:0] addr,
  output logic [31:0] wdata,
  input wire logic [31:0] rdata
);
  initial begin
    rd = 1'b0;
    wr = 1'b0;
    addr = 12'hFFC;
    wdata = 32'h0;
  end
  // Strobes for one rising edge, then takes the registered read data.
  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(negedge ref_clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(negedge ref_clk);
    rd <= 1'b0;
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    r = rdata;
  endtask
endmodule
`default_nettype wire

/* dv/test_mqu_top.sv */
// Self-checking bench of the message queue unit.
`timescale 1ns/1ps
`default_nettype none
module test_mqu_top;
  import mqu_pkg::*;
  logic ref_clk, rst, host_rd, host_wr, local_rd, local_wr, host_irq, local_irq;
  logic [11:0] host_addr, local_addr;
  logic [31:0] host_wdata, host_rdata, local_wdata, local_rdata, rv;
  int errors, checks, seed;
  logic hm, lm;
  logic [31:0] mq[4][$];
  mqu_top #(.DEPTH(MQU_DEPTH)) DUT (.ref_clk(ref_clk), .rst(rst), .host_rd(host_rd),
    .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .local_rd(local_rd), .local_wr(local_wr),
    .local_addr(local_addr), .local_wdata(local_wdata), .local_rdata(local_rdata),
    .host_irq(host_irq), .local_irq(local_irq));
  mqu_bus_agent host_bus (.ref_clk(ref_clk), .rd(host_rd), .wr(host_wr), .addr(host_addr),
    .wdata(host_wdata), .rdata(host_rdata));
  mqu_bus_agent local_bus (.ref_clk(ref_clk), .rd(local_rd), .wr(local_wr),
    .addr(local_addr), .wdata(local_wdata), .rdata(local_rdata));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Queue read at each port offset; the write side is the partner queue.
  function automatic logic [1:0] rsel(input logic [11:0] a);
    case (a)
      MQU_OFF_IBFP_PORT: return MQU_Q_IN_FREE;
      MQU_OFF_OBPF_PORT: return MQU_Q_OUT_POST;
      MQU_OFF_IBPF_PORT: return MQU_Q_IN_POST;
      default: return MQU_Q_OUT_FREE;
    endcase
  endfunction
  function automatic logic [1:0] wsel(input logic [11:0] a);
    return rsel(a ^ 12'h008);
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic acc(input logic side, input logic w, input logic [11:0] a,
      input logic [31:0] d);
    logic [31:0] r, e;
    logic isq;
    isq = (a >= MQU_OFF_IBFP_PORT) && (a <= MQU_OFF_OBFP_PORT);
    case (a)
      MQU_OFF_HOST_STATUS: e = {28'h0, mq[MQU_Q_OUT_POST].size() != 0, 3'h0};
      MQU_OFF_HOST_MASK: e = {28'hFFFFFFF, hm, 3'h7};
      MQU_OFF_LOCAL_STATUS: e = {28'h0, mq[MQU_Q_IN_POST].size() != 0, 3'h0};
      MQU_OFF_LOCAL_MASK: e = {28'hFFFFFFF, lm, 3'h7};
      default: e = 32'h0;
    endcase
    if (side) local_bus.access(w, a, d, r);
    else host_bus.access(w, a, d, r);
    if (w) begin
      if (isq && mq[wsel(a)].size() < MQU_DEPTH) mq[wsel(a)].push_back(d);
      if (!side && a == MQU_OFF_HOST_MASK) hm = d[3];
      if (side && a == MQU_OFF_LOCAL_MASK) lm = d[3];
    end else begin
      if (isq) e = (mq[rsel(a)].size() != 0) ? mq[rsel(a)].pop_front() : 32'hFFFFFFFF;
      cmp(r, e, "read data");
    end
    cmp({30'h0, host_irq, local_irq}, {30'h0, mq[MQU_Q_OUT_POST].size() != 0 && !hm,
      mq[MQU_Q_IN_POST].size() != 0 && !lm}, "irq");
  endtask
  task automatic do_reset(input int n);
    @(negedge ref_clk);
    rst <= 1'b1;
    repeat (n) @(negedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) mq[i].delete();
    hm = 1'b1;
    lm = 1'b1;
  endtask
  task automatic all_regs();
    for (int i = 0; i < 8; i++) acc(i[0], 1'b0, 12'h030 + 12'(i * 4), 32'h0);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    $display("[ERR] %0t run did not finish", $time);
    give_verdict();
  end
  initial begin
    seed = 62;
    rst = 1'b1;
    do_reset(6);
    all_regs();
    acc(1'b0, 1'b0, 12'h050, 32'h0);
    acc(1'b1, 1'b0, 12'h002, 32'h0);
    $display("test reset values done");
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 3; k++) acc(p[1], 1'b1, 12'h040 + 12'(p * 4), $random(seed));
      acc(1'b0, 1'b0, MQU_OFF_HOST_STATUS, 32'h0);
      acc(1'b1, 1'b0, MQU_OFF_LOCAL_STATUS, 32'h0);
      for (int k = 0; k < 4; k++) acc(~p[1], 1'b0, (12'h040 + 12'(p * 4)) ^ 12'h008, 32'h0);
    end
    $display("test queue routing done");
    acc(1'b1, 1'b1, MQU_OFF_LOCAL_MASK, 32'h0);
    acc(1'b0, 1'b1, MQU_OFF_HOST_MASK, 32'h0);
    acc(1'b0, 1'b1, MQU_OFF_IBFP_PORT, $random(seed));
    acc(1'b1, 1'b1, MQU_OFF_OBFP_PORT, $random(seed));
    acc(1'b0, 1'b0, MQU_OFF_HOST_MASK, 32'h0);
    acc(1'b1, 1'b0, MQU_OFF_LOCAL_MASK, 32'h0);
    acc(1'b0, 1'b1, MQU_OFF_LOCAL_MASK, 32'hFFFFFFFF);
    acc(1'b1, 1'b1, MQU_OFF_LOCAL_MASK, 32'hFFFFFFFF);
    $display("test status and mask done");
    for (int k = 0; k <= MQU_DEPTH; k++) acc(1'b0, 1'b1, MQU_OFF_IBFP_PORT, $random(seed));
    for (int k = 0; k <= MQU_DEPTH; k++) acc(1'b1, 1'b0, MQU_OFF_IBPF_PORT, 32'h0);
    $display("test full queue done");
    for (int k = 0; k < 300; k++) begin
      rv = $random(seed);
      acc(rv[0], rv[1], 12'h030 + {6'h0, rv[5:2], 2'h0}, $random(seed));
    end
    $display("test random traffic done");
    acc(1'b0, 1'b1, MQU_OFF_IBFP_PORT, $random(seed));
    acc(1'b1, 1'b1, MQU_OFF_LOCAL_MASK, 32'h0);
    do_reset(2);
    all_regs();
    $display("test reset in run done");
    give_verdict();
  end
endmodule
`default_nettype wire
